// file: bench/aipc_sensor_model.sv
// image sensor timing source model that drives the clamp pulse pin
`timescale 1ns/100ps
module aipc_sensor_model (
  input  wire logic       clk,
  input  wire logic       en,
  input  wire logic [3:0] black_len,
  output logic            clamp_pulse
);
  logic [3:0] pix;

  // ----------------------------------------------------------------
  // line timing: black pixels lead each 16-pixel line
  // ----------------------------------------------------------------
  // pulse only over the black pixels, where the input level is known
  always @(negedge clk) begin
    pix <= en ? pix + 4'h1 : 4'h0;
    clamp_pulse <= en && (pix < black_len);
  end
endmodule

// file: bench/tb.sv
// self-checking bench for the input phase and clamp control
`timescale 1ns/100ps
`include "aipc_consts.svh"
module tb;
  import aipc_pkg::*;
  logic       clk, rst, wr, rd, pin_en, clamp_chk, gated;
  logic       rvalid, strobe, sel, clamp, pos, pas, act, overvoltage_clamp, pulse;
  aipc_byte_t addr, wdata, rdata;
  aipc_byte_t gain[12];
  logic [2:0] hist;
  logic [1:0] sl;
  logic [3:0] blk;
  int         mismatches, num_checks, cyc, d3, d;
  aipc_byte_t exp_q[$];

  aipc_top i_dut (.REF_CLK(clk), .RESET(rst), .CLAMP_PULSE_IN(pulse), .REG_WR(wr),
    .REG_RD(rd), .REG_ADDR(addr), .REG_WDATA(wdata), .REG_RDATA(rdata),
    .REG_RVALID(rvalid), .SAMPLE_STROBE(strobe), .ADC_CHAN_SEL(sel),
    .CLAMP_SWITCH(clamp), .POSITIVE_POLARITY(pos), .PASSIVE_BIAS_ENABLE(pas),
    .ACTIVE_BIAS_ENABLE(act), .OVERVOLTAGE_CLAMP(overvoltage_clamp));

  aipc_sensor_model i_sensor (.clk(clk), .en(pin_en), .black_len(blk), .clamp_pulse(pulse));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic chk(string name, logic [7:0] seen, logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // one request per cycle; the next op overrides, so back to back is possible
  task automatic op(logic r, aipc_byte_t a, aipc_byte_t v);
    @(negedge clk);
    rd = r;
    wr = !r;
    addr = a;
    wdata = v;
    if (r) exp_q.push_back(v);
  endtask

  task automatic idle(int n);
    @(negedge clk);
    rd = 1'b0;
    wr = 1'b0;
    repeat (n) @(negedge clk);
  endtask

  // cycles from a channel-pair toggle to the next sample strobe
  task automatic meas(output int n);
    logic s;
    idle(8);
    s = sel;
    n = 0;
    while (sel === s && n < 8) begin
      @(negedge clk);
      n++;
    end
    n = 0;
    while (strobe !== 1'b1 && n < 8) begin
      @(negedge clk);
      n++;
    end
    s = sel;
    repeat (4) @(negedge clk);
    chk("strobe", strobe, 1);
    chk("chan_sel", sel, !s);
  endtask

  // ----------------------------------------------------------------
  // clock, watchdog and output monitor
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  always @(posedge clk) begin
    hist <= {hist[1:0], pulse};
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      mismatches++;
      end_sim();
    end
  end

  always @(negedge clk) begin
    if (rvalid === 1'b1) begin
      if (exp_q.size() == 0) chk("rvalid", rvalid, 0);
      else chk("rdata", rdata, exp_q.pop_front());
    end
    if (clamp_chk) chk("clamp", clamp, hist[2] & (strobe | !gated));
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    rst = 1'b1;
    wr = 1'b0;
    rd = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
    pin_en = 1'b0;
    clamp_chk = 1'b0;
    gated = 1'b0;
    blk = 4'h4;
    void'($urandom(32'h6BF3));
    repeat (3) @(negedge clk);
    rst = 1'b0;
    chk("ovp", overvoltage_clamp, 1);
    chk("bias", {pas, act}, 0);
    chk("pos", pos, 0);
    op(1, `AIPC_OFS_COND_CFG, `AIPC_RST_COND_CFG);
    op(1, `AIPC_OFS_PHASE_CFG, `AIPC_RST_PHASE_CFG);
    op(1, `AIPC_OFS_BIAS_CFG, `AIPC_RST_BIAS_CFG);
    op(1, 8'h40, 8'h00);
    meas(d3);
    // bit 2 selects three-channel mode, so all eight codes cover both modes
    for (int p = 0; p < 8; p++) begin
      op(0, `AIPC_OFS_PHASE_CFG, 8'(p));
      meas(d);
      sl = p[2] ? {p[0], 1'b1} : p[1:0];
      chk("phase", 8'((d3 - d) & 3), 8'(3 - sl));
    end
    for (int i = 0; i < 12; i++) begin
      gain[i] = 8'($urandom);
      op(0, (i < 6 ? `AIPC_OFS_GAIN_BASE : `AIPC_OFS_OFFSET_BASE - 8'h06) + 8'(i), gain[i]);
    end
    for (int i = 0; i < 12; i++) begin
      op(1, (i < 6 ? `AIPC_OFS_GAIN_BASE : `AIPC_OFS_OFFSET_BASE - 8'h06) + 8'(i), gain[i]);
    end
    op(0, `AIPC_OFS_GAIN_BASE + 8'h02, 8'h5A);
    op(1, `AIPC_OFS_GAIN_BASE + 8'h02, 8'h5A);
    op(0, 8'h16, 8'hA5);
    op(1, 8'h16, 8'h00);
    op(0, `AIPC_OFS_COND_CFG, 8'h80);
    op(1, `AIPC_OFS_COND_CFG, 8'h80);
    idle(3);
    chk("pos", pos, 0);
    op(0, `AIPC_OFS_PHASE_CFG, 8'h0B);
    idle(3);
    chk("pos", pos, 1);
    op(0, `AIPC_OFS_BIAS_CFG, 8'h07);
    idle(3);
    chk("bias", {overvoltage_clamp, pas, act}, 8'h04);
    op(0, `AIPC_OFS_BIAS_CFG, 8'hFB);
    idle(3);
    chk("bias", {overvoltage_clamp, pas, act}, 8'h03);
    op(1, `AIPC_OFS_BIAS_CFG, 8'h03);
    op(0, `AIPC_OFS_BIAS_CFG, 8'h00);
    idle(3);
    chk("bias", {overvoltage_clamp, pas, act}, 8'h00);
    // ungated pass first, then gated as a host normally sets it
    for (int g = 0; g < 2; g++) begin
      gated = g[0];
      op(0, `AIPC_OFS_COND_CFG, {4'h0, g[0], 3'h0});
      blk = 4'($urandom_range(9, 4));
      pin_en = 1'b1;
      idle(6);
      clamp_chk = 1'b1;
      repeat (64) @(negedge clk);
      clamp_chk = 1'b0;
      pin_en = 1'b0;
    end
    // a second reset mid-run must restore the phase, condition and bias settings
    idle(2);
    rst = 1'b1;
    repeat (3) @(negedge clk);
    rst = 1'b0;
    chk("ovp", overvoltage_clamp, 1);
    chk("pos", pos, 0);
    op(1, `AIPC_OFS_PHASE_CFG, `AIPC_RST_PHASE_CFG);
    op(1, `AIPC_OFS_COND_CFG, `AIPC_RST_COND_CFG);
    idle(4);
    end_sim();
  end
endmodule

// file: src/aipc_chan_mem.sv
// per-channel gain and offset storage with registered read data
`timescale 1ns/100ps
module aipc_chan_mem (
  input  wire logic               clk,
  input  wire logic               wr_en,
  input  wire aipc_pkg::aipc_idx_t wr_idx,
  input  wire aipc_pkg::aipc_byte_t wr_data,
  input  wire aipc_pkg::aipc_idx_t rd_idx,
  output aipc_pkg::aipc_byte_t    rd_data_q
);
  import aipc_pkg::*;

  aipc_byte_t mem [0:15];

  // only the addressed word changes; every other channel keeps its value
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_idx] <= wr_data; // RL5
    end
  end

  always_ff @(posedge clk) begin
    rd_data_q <= mem[rd_idx];
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_write_read_back;
    aipc_idx_t i;
    aipc_byte_t d;
    @(posedge clk) (wr_en, i = wr_idx, d = wr_data) ##1 (!wr_en && rd_idx == i)
      |=> rd_data_q == d;
  endproperty
  a_write_read_back: assert property (p_write_read_back) // RL5
    else $error("channel setting not held after write");
endmodule

// file: src/aipc_consts.svh
// register offsets, field positions, reset values and timing counts for the input stage control
`ifndef AIPC_CONSTS_SVH
`define AIPC_CONSTS_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define AIPC_OFS_COND_CFG     8'h03
`define AIPC_OFS_PHASE_CFG    8'h04
`define AIPC_OFS_BIAS_CFG     8'h05
`define AIPC_OFS_GAIN_BASE    8'h10
`define AIPC_OFS_OFFSET_BASE  8'h18

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define AIPC_BIT_POLARITY     7
`define AIPC_BIT_CLAMP_GATE   3
`define AIPC_BIT_THREE_CH     2
`define AIPC_BIT_SH_MODE      3
`define AIPC_BIT_PASSIVE      0
`define AIPC_BIT_ACTIVE       1
`define AIPC_BIT_OVP          2

// ----------------------------------------------------------------
// reset values and timing
// ----------------------------------------------------------------
`define AIPC_RST_COND_CFG     8'h00
`define AIPC_RST_PHASE_CFG    8'h03
`define AIPC_RST_BIAS_CFG     8'h04
`define AIPC_CHANNELS         3'h6
`define AIPC_PIXEL_CLKS       2'h3

`endif

// file: src/aipc_pkg.sv
// types shared by the input stage control files
package aipc_pkg;
  typedef logic [7:0] aipc_byte_t;
  typedef logic [3:0] aipc_idx_t;
  typedef logic [1:0] aipc_phase_t;
  typedef enum logic {AIPC_SIX_CH, AIPC_THREE_CH} aipc_mode_t;
endpackage

// file: src/aipc_top.sv
// input phase, channel routing, clamp, polarity and bias control of the analog front end
//
// Summary of operation
// RL1: four sample phases in six-channel mode, two in three-channel mode.
// RL2: phase field resets to 11, read as X1 in three-channel mode.
// RL3: 10, 01, 00 sample earlier by one, two, three quarter pixels.
// RL4: six channels share three converters; each converter alternates a channel pair.
// RL5: every channel keeps its own gain and offset setting.
// RL6: clamp switch comes from clamp pulse, gate enable and sample strobe.
// RL7: ungated, clamp follows pulse; gated, pulse and strobe both needed.
// RL8: host should normally set the clamp gate bit, bit 3 of 0x03.
// RL9: timing source asserts clamp pulse during the black portion only.
// RL10: bit 7 of 0x03 picks polarity: 0 negative (default), 1 positive.
// RL11: positive polarity works only in sample-and-hold; negative in both modes.
// RL12: passive bias enable ties 1 kOhm resistors to inputs toward half supply.
// RL13: active bias enable switches external clamp reference onto the inputs.
// RL14: host clears both bias enables before acquisition starts.
// RL15: overvoltage clamp on at power up; bias only after it is off.
// RL16: host turns biasing off again once inputs have charged.
// RL17: clamp pulse is sampled on the rising master clock edge.
// RL18: three-channel mode decodes only the low phase bit.
`timescale 1ns/100ps
`include "aipc_consts.svh"
module aipc_top (
  input  wire logic                 REF_CLK,
  input  wire logic                 RESET,
  input  wire logic                 CLAMP_PULSE_IN,
  input  wire logic                 REG_WR,
  input  wire logic                 REG_RD,
  input  wire aipc_pkg::aipc_byte_t REG_ADDR,
  input  wire aipc_pkg::aipc_byte_t REG_WDATA,
  output aipc_pkg::aipc_byte_t      REG_RDATA,
  output logic                      REG_RVALID,
  output logic                      SAMPLE_STROBE,
  output logic                      ADC_CHAN_SEL,
  output logic                      CLAMP_SWITCH,
  output logic                      POSITIVE_POLARITY,
  output logic                      PASSIVE_BIAS_ENABLE,
  output logic                      ACTIVE_BIAS_ENABLE,
  output logic                      OVERVOLTAGE_CLAMP
);
  import aipc_pkg::*;

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  function automatic logic chan_hit(input aipc_byte_t a);
    chan_hit = (a[7:4] == 4'(`AIPC_OFS_GAIN_BASE >> 4)) && (a[2:0] < `AIPC_CHANNELS);
  endfunction

  function automatic aipc_idx_t chan_idx(input aipc_byte_t a);
    chan_idx = a[3:0];
  endfunction

  aipc_byte_t  cond_q, phase_q, bias_q;
  logic        clamp_s1_q, clamp_s2_q;
  logic [1:0]  pix_cnt_q;
  logic        rd_q, rd_mem_q;
  aipc_byte_t  rd_reg_q;
  aipc_byte_t  mem_rdata;

  wire         wr_cond   = REG_WR && (REG_ADDR == `AIPC_OFS_COND_CFG);
  wire         wr_phase  = REG_WR && (REG_ADDR == `AIPC_OFS_PHASE_CFG);
  wire         wr_bias   = REG_WR && (REG_ADDR == `AIPC_OFS_BIAS_CFG);
  wire         wr_mem    = REG_WR && chan_hit(REG_ADDR);
  aipc_byte_t  rd_value;

  always_comb begin
    if (REG_ADDR == `AIPC_OFS_COND_CFG) begin
      rd_value = cond_q;
    end else if (REG_ADDR == `AIPC_OFS_PHASE_CFG) begin
      rd_value = phase_q;
    end else if (REG_ADDR == `AIPC_OFS_BIAS_CFG) begin
      rd_value = bias_q;
    end else begin
      rd_value = 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // field views
  // ----------------------------------------------------------------
  aipc_mode_t  chan_mode;
  aipc_phase_t sample_pos;
  wire         gate_en   = cond_q[`AIPC_BIT_CLAMP_GATE];
  wire         sh_mode   = phase_q[`AIPC_BIT_SH_MODE];
  wire         ovp_on    = bias_q[`AIPC_BIT_OVP];
  assign chan_mode = phase_q[`AIPC_BIT_THREE_CH] ? AIPC_THREE_CH : AIPC_SIX_CH;
  // 11 is the latest sampling slot; each step down samples a quarter pixel earlier
  assign sample_pos = (chan_mode == AIPC_THREE_CH) ? {phase_q[0], 1'b1} // RL18
                                                   : phase_q[1:0];      // RL3
  wire         strobe_d  = (pix_cnt_q == sample_pos); // RL1
  wire         clamp_d   = clamp_s2_q && (!gate_en || strobe_d); // RL6 RL7

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      cond_q  <= `AIPC_RST_COND_CFG; // RL10
      phase_q <= `AIPC_RST_PHASE_CFG; // RL2
      bias_q  <= `AIPC_RST_BIAS_CFG; // RL15
    end else begin
      if (wr_cond) begin
        cond_q <= REG_WDATA;
      end
      if (wr_phase) begin
        phase_q <= {4'h0, REG_WDATA[3:0]};
      end
      if (wr_bias) begin
        bias_q <= {5'h00, REG_WDATA[2:0]};
      end
    end
  end

  // pixel timing: one pixel spans four master clocks, giving quarter-pixel steps
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      pix_cnt_q    <= 2'h0;
      ADC_CHAN_SEL <= 1'b0;
    end else begin
      pix_cnt_q <= pix_cnt_q + 2'h1;
      if (pix_cnt_q == `AIPC_PIXEL_CLKS) begin
        ADC_CHAN_SEL <= !ADC_CHAN_SEL; // RL4
      end
    end
  end

  // the pin is asynchronous to the master clock, hence two stages
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      clamp_s1_q <= 1'b0;
      clamp_s2_q <= 1'b0;
    end else begin
      clamp_s1_q <= CLAMP_PULSE_IN; // RL17
      clamp_s2_q <= clamp_s1_q;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      SAMPLE_STROBE       <= 1'b0;
      CLAMP_SWITCH        <= 1'b0;
      POSITIVE_POLARITY   <= 1'b0;
      PASSIVE_BIAS_ENABLE <= 1'b0;
      ACTIVE_BIAS_ENABLE  <= 1'b0;
      OVERVOLTAGE_CLAMP   <= 1'b1;
    end else begin
      SAMPLE_STROBE       <= strobe_d;
      CLAMP_SWITCH        <= clamp_d; // RL7
      // positive polarity has no meaning in correlated double sampling
      POSITIVE_POLARITY   <= cond_q[`AIPC_BIT_POLARITY] && sh_mode; // RL10 RL11
      // bias is held off while the overvoltage clamp still carries current
      PASSIVE_BIAS_ENABLE <= bias_q[`AIPC_BIT_PASSIVE] && !ovp_on; // RL12 RL15
      ACTIVE_BIAS_ENABLE  <= bias_q[`AIPC_BIT_ACTIVE] && !ovp_on; // RL13 RL15
      OVERVOLTAGE_CLAMP   <= ovp_on; // RL15
    end
  end

  // ----------------------------------------------------------------
  // register read path, two cycles for every address
  // ----------------------------------------------------------------
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      rd_q       <= 1'b0;
      rd_mem_q   <= 1'b0;
      rd_reg_q   <= 8'h00;
      REG_RVALID <= 1'b0;
      REG_RDATA  <= 8'h00;
    end else begin
      rd_q       <= REG_RD;
      rd_mem_q   <= chan_hit(REG_ADDR);
      rd_reg_q   <= rd_value;
      REG_RVALID <= rd_q;
      if (rd_q) begin
        REG_RDATA <= rd_mem_q ? mem_rdata : rd_reg_q;
      end
    end
  end

  aipc_chan_mem u_chan_mem (
    .clk       (REF_CLK),
    .wr_en     (wr_mem),
    .wr_idx    (chan_idx(REG_ADDR)),
    .wr_data   (REG_WDATA),
    .rd_idx    (chan_idx(REG_ADDR)),
    .rd_data_q (mem_rdata)
  );

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RESET);

  sequence s_pulse_seen;
    CLAMP_PULSE_IN ##2 !gate_en;
  endsequence

  property p_strobe_slot;
    SAMPLE_STROBE |-> $past(pix_cnt_q) == $past(sample_pos);
  endproperty
  a_strobe_slot: assert property (p_strobe_slot) // RL3
    else $error("sample strobe not in selected quarter slot");

  // a phase write may legally move the slot right behind the old one
  property p_strobe_once_per_pixel;
    SAMPLE_STROBE && !$past(wr_phase) |=> !SAMPLE_STROBE;
  endproperty
  a_strobe_once_per_pixel: assert property (p_strobe_once_per_pixel) // RL1
    else $error("sample strobe longer than one clock");

  property p_three_ch_slots;
    (SAMPLE_STROBE && $past(chan_mode) == AIPC_THREE_CH) |-> $past(pix_cnt_q[0]);
  endproperty
  a_three_ch_slots: assert property (p_three_ch_slots) // RL18
    else $error("three channel mode sampled in an even slot");

  property p_mux_alternates;
    $changed(ADC_CHAN_SEL) |=> $stable(ADC_CHAN_SEL) [*3] ##1 $changed(ADC_CHAN_SEL);
  endproperty
  a_mux_alternates: assert property (p_mux_alternates) // RL4
    else $error("converter channel pair not alternating per pixel");

  property p_clamp_ungated;
    s_pulse_seen |=> CLAMP_SWITCH;
  endproperty
  a_clamp_ungated: assert property (p_clamp_ungated) // RL7 RL17
    else $error("ungated clamp did not follow the pulse");

  property p_clamp_cause;
    CLAMP_SWITCH |-> $past(CLAMP_PULSE_IN, 3) && ($past(!gate_en) || SAMPLE_STROBE);
  endproperty
  a_clamp_cause: assert property (p_clamp_cause) // RL6
    else $error("clamp closed without pulse or gate condition");

  property p_phase_reset;
    $fell(RESET) |-> phase_q[1:0] == 2'h3 && !POSITIVE_POLARITY;
  endproperty
  a_phase_reset: assert property (@(posedge REF_CLK) p_phase_reset) // RL2
    else $error("phase field or polarity wrong after reset");

  property p_positive_needs_sh;
    POSITIVE_POLARITY |-> $past(sh_mode);
  endproperty
  a_positive_needs_sh: assert property (p_positive_needs_sh) // RL11
    else $error("positive polarity outside sample and hold");

  property p_bias_after_ovp;
    (PASSIVE_BIAS_ENABLE || ACTIVE_BIAS_ENABLE) |-> !OVERVOLTAGE_CLAMP;
  endproperty
  a_bias_after_ovp: assert property (p_bias_after_ovp) // RL15
    else $error("input bias enabled while overvoltage clamp active");
endmodule
